// File: nvmpe_core.sv
/*
  Program flash, program once and erase all blocks command sequencer.
  Assumes a plain register port synchronous to I_CLK, read data one cycle
  after the read strobe, and an array model outside reporting verify result.
*/
// Local design decisions: the address map and the address-and-strobe port.
// Notes on behaviour
// RQ1: Software puts code 06 and address bits 23..16 at index 0.
// RQ2: Index 1 holds address bits 15..0, low two bits zero.
// RQ3: Program flash writes one or two longwords from indices 2..5.
// RQ4: Clearing complete flag launches program, verify, then sets complete.
// RQ5: Program flash launch index must be 3 or 5, else access error.
// RQ6: Command not allowed in current mode gives access error.
// RQ7: Bad address, misalignment or overrun past block end gives access error.
// RQ8: Program flash into protected region sets protection violation.
// RQ9: Verify sets error bit on any error, second bit if uncorrectable.
// RQ10: Program once uses code 07, phrase 0..7, four data words.
// RQ11: Program once blank-checks, programs, verifies, completes when done.
// RQ12: Program once needs launch index 5 and valid phrase index.
// RQ13: Programmed phrase refused unless its value was all ones.
// RQ14: Flash reads invalid during program once; never protection error.
// RQ15: Erase all uses code 08, launch index must be 0.
// RQ16: Erase all erases, verifies, and unsecures on success.
// RQ17: Erase all with any protected region sets protection violation.
// RQ18: Software writes no register while erase all runs.
// RQ19: Software programs only erased phrases.
// RQ20: Address bit 23 picks flash (0) or EEPROM (1).
// RQ21: Launch errors start no operation and set complete again.
`timescale 1ns/1ps
`default_nettype none
`include "nvmpe_params.svh"

module nvmpe_core
  import nvmpe_pkg::*;
(
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RESETN,
  // Register port
  input  wire logic [2:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  // Device state
  input  wire logic        i_mode_ok,
  input  wire logic        i_flash_prot,
  input  wire logic        i_ee_prot,
  input  wire logic        i_verify_err,
  input  wire logic        i_verify_unc,
  input  wire logic        i_phrase_blank,
  input  wire logic        i_phrase_ones,
  // Array control
  output logic             o_prog,
  output logic             o_erase_all,
  output logic             o_array_sel,
  output logic      [15:0] o_array_addr,
  output logic      [63:0] o_prog_data,
  output logic             o_once_sel,
  output logic             o_read_invalid,
  output logic             o_unsecure
);

  // Parameter array, six 16-bit entries
  logic [15:0]  param [0:5];
  logic [15:0]  next_param [0:5];
  logic [2:0]   parameter_index, next_parameter_index;
  nvmpe_flags_t flags, next_flags;
  nvmpe_state_t state, next_state;
  logic [7:0]   timer, next_timer;
  logic [7:0]   rdata, next_rdata;
  logic         prog, next_prog;
  logic         erase, next_erase;
  logic         sel, next_sel;
  logic [15:0]  aaddr, next_aaddr;
  logic [63:0]  pdata, next_pdata;
  logic         once, next_once;
  logic         unsec, next_unsec;
  logic         launch;

  // Status byte from flags
  function automatic logic [7:0] status_byte(input nvmpe_flags_t f);
    logic [7:0] s;
    s = 8'h00;
    s[`NVMPE_ST_CCF]  = f.ccf;
    s[`NVMPE_ST_ACC]  = f.acc;
    s[`NVMPE_ST_PROT] = f.prot;
    s[`NVMPE_ST_VERR] = f.verr;
    s[`NVMPE_ST_VUNC] = f.vunc;
    return s;
  endfunction : status_byte

  // Launch: software writes one to the complete flag while idle
  assign launch = i_wr && (i_addr == `NVMPE_OFS_STATUS) && flags.ccf &&
                  i_wdata[`NVMPE_ST_CCF];

  // Register writes, launch checks and sequencing
  always_comb begin
    logic [7:0]  code;
    logic [15:0] last;
    logic        acc;
    logic        prot;
    code = param[0][15:8];
    last = 16'h0000;
    acc  = 1'b0;
    prot = 1'b0;
    for (int i = 0; i < 6; i++) begin
      next_param[i] = param[i];
    end
    next_parameter_index = parameter_index;
    next_flags = flags;
    next_state = state;
    next_timer = timer;
    next_prog = 1'b0;
    next_erase = 1'b0;
    next_sel = sel;
    next_aaddr = aaddr;
    next_pdata = pdata;
    next_once = once;
    next_unsec = unsec;
    next_rdata = 8'h00;
    // Writes are accepted only while no command runs [RQ18]
    if (i_wr && flags.ccf) begin
      if (i_addr == `NVMPE_OFS_INDEX) begin
        next_parameter_index = i_wdata[2:0];
      end else if (i_addr == `NVMPE_OFS_PARHI) begin
        if (parameter_index <= 3'h5) begin
          next_param[parameter_index][15:8] = i_wdata;
        end
      end else if (i_addr == `NVMPE_OFS_PARLO) begin
        if (parameter_index <= 3'h5) begin
          next_param[parameter_index][7:0] = i_wdata;
        end
      end else if (i_addr == `NVMPE_OFS_STATUS) begin
        // Write-one-to-clear of the access and protection error flags
        if (i_wdata[`NVMPE_ST_ACC]) next_flags.acc = 1'b0;
        if (i_wdata[`NVMPE_ST_PROT]) next_flags.prot = 1'b0;
      end
    end
    // Read data one cycle after the strobe
    if (i_rd) begin
      if (i_addr == `NVMPE_OFS_INDEX) begin
        next_rdata = {5'h00, parameter_index};
      end else if (i_addr == `NVMPE_OFS_PARHI) begin
        next_rdata = (parameter_index <= 3'h5) ?
                     param[parameter_index][15:8] : 8'h00;
      end else if (i_addr == `NVMPE_OFS_PARLO) begin
        next_rdata = (parameter_index <= 3'h5) ?
                     param[parameter_index][7:0] : 8'h00;
      end else if (i_addr == `NVMPE_OFS_STATUS) begin
        next_rdata = status_byte(flags);
      end else begin
        next_rdata = 8'h00;
      end
    end
    // Sequencer
    case (state)
      NVMPE_IDLE: begin
        if (launch && !flags.acc && !flags.prot) begin
          next_flags.ccf  = 1'b0; // [RQ4]
          next_flags.verr = 1'b0;
          next_flags.vunc = 1'b0;
          next_state = NVMPE_CHECK;
        end
      end
      NVMPE_CHECK: begin
        next_sel = param[0][7]; // [RQ20]
        last = param[0][7] ? `NVMPE_EE_LAST : `NVMPE_FLASH_LAST;
        if (!i_mode_ok) acc = 1'b1; // [RQ6]
        if (code == `NVMPE_CMD_PGM) begin
          // [RQ5]
          if (parameter_index != `NVMPE_IX_ONE &&
              parameter_index != `NVMPE_IX_TWO) acc = 1'b1;
          // [RQ7]
          if (param[0][6:0] != 7'h00) acc = 1'b1;
          if (param[1][1:0] != 2'b00) acc = 1'b1;
          if (param[1] > last) acc = 1'b1;
          if (parameter_index == `NVMPE_IX_TWO && param[1] == last)
            acc = 1'b1;
          prot = param[0][7] ? i_ee_prot : i_flash_prot; // [RQ8]
          next_aaddr = param[1];
          // Unused second longword stays erased (all ones) [RQ3]
          next_pdata[63:32] = {param[2], param[3]};
          next_pdata[31:0]  = (parameter_index == `NVMPE_IX_TWO) ?
                              {param[4], param[5]} : 32'hFFFF_FFFF;
          next_once = 1'b0;
        end else if (code == `NVMPE_CMD_ONCE) begin
          // [RQ12]
          if (parameter_index != `NVMPE_IX_TWO) acc = 1'b1;
          if (param[1] > `NVMPE_ONCE_MAX) acc = 1'b1;
          next_aaddr = param[1];
          // Whole phrase goes out, never trimmed to one longword [RQ11]
          next_pdata = {param[2], param[3], param[4], param[5]};
          next_once = 1'b1; // No protection check here [RQ14]
        end else if (code == `NVMPE_CMD_ERALL) begin
          if (parameter_index != `NVMPE_IX_HDR) acc = 1'b1; // [RQ15]
          prot = i_flash_prot || i_ee_prot; // [RQ17]
          next_once = 1'b0;
        end else begin
          acc = 1'b1;
        end
        next_flags.acc  = acc;
        next_flags.prot = prot && !acc;
        if (acc || prot) begin
          // Abort without touching memory [RQ21]
          next_flags.ccf = 1'b1;
          next_once = 1'b0;
          next_state = NVMPE_IDLE;
        end else if (code == `NVMPE_CMD_ONCE) begin
          next_state = NVMPE_BLANK;
        end else begin
          next_timer = `NVMPE_OP_CYCLES;
          next_prog  = (code == `NVMPE_CMD_PGM);
          next_erase = (code == `NVMPE_CMD_ERALL);
          next_state = NVMPE_PROG;
        end
      end
      NVMPE_BLANK: begin
        // [RQ11] [RQ13]
        if (i_phrase_blank || i_phrase_ones) begin
          next_timer = `NVMPE_OP_CYCLES;
          next_prog  = 1'b1;
          next_state = NVMPE_PROG;
        end else begin
          next_flags.acc = 1'b1;
          next_flags.ccf = 1'b1;
          next_once = 1'b0;
          next_state = NVMPE_IDLE;
        end
      end
      NVMPE_PROG: begin
        if (timer == 8'h00) begin
          next_state = NVMPE_VERIFY;
        end else begin
          next_timer = timer - 8'h01;
        end
      end
      NVMPE_VERIFY: begin
        // Read-back result [RQ9]
        next_flags.verr = i_verify_err || i_verify_unc;
        next_flags.vunc = i_verify_unc;
        if (code == `NVMPE_CMD_ERALL && !i_verify_err && !i_verify_unc)
          next_unsec = 1'b1; // [RQ16]
        next_flags.ccf = 1'b1; // [RQ4] [RQ11]
        next_once = 1'b0;
        next_state = NVMPE_IDLE;
      end
      default: begin
        next_state = NVMPE_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      for (int i = 0; i < 6; i++) begin
        param[i] <= 16'h0000;
      end
      parameter_index <= 3'h0;
      flags <= '{ccf: 1'b1, acc: 1'b0, prot: 1'b0, verr: 1'b0, vunc: 1'b0};
      state <= NVMPE_IDLE;
      timer <= 8'h00;
      rdata <= 8'h00;
      prog <= 1'b0;
      erase <= 1'b0;
      sel <= 1'b0;
      aaddr <= 16'h0000;
      // Second longword shows erased until the first program flash or program once command is checked
      pdata <= 64'h0000_0000_FFFF_FFFF;
      once <= 1'b0;
      unsec <= 1'b0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        param[i] <= next_param[i];
      end
      parameter_index <= next_parameter_index;
      flags <= next_flags;
      state <= next_state;
      timer <= next_timer;
      rdata <= next_rdata;
      prog <= next_prog;
      erase <= next_erase;
      sel <= next_sel;
      aaddr <= next_aaddr;
      pdata <= next_pdata;
      once <= next_once;
      unsec <= next_unsec;
    end
  end

  // Outputs straight from flip-flops
  assign o_rdata        = rdata;
  assign o_prog         = prog;
  assign o_erase_all    = erase;
  assign o_array_sel    = sel;
  assign o_array_addr   = aaddr;
  assign o_prog_data    = pdata;
  assign o_once_sel     = once;
  assign o_read_invalid = once; // [RQ14]
  assign o_unsecure     = unsec;

endmodule : nvmpe_core
`default_nettype wire

// File: nvmpe_core_properties.sv
/* Port checker for nvmpe_core.
   Assumes it is bound onto nvmpe_core with matching port names. */
`timescale 1ns/1ps
`default_nettype none
module nvmpe_props (
  // Clock, reset and read side
  input wire logic       I_CLK,
  input wire logic       I_RESETN,
  input wire logic [2:0] i_addr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  // Device state
  input wire logic       i_mode_ok,
  input wire logic       i_flash_prot,
  input wire logic       i_ee_prot,
  input wire logic       i_verify_err,
  // Array control
  input wire logic       o_prog,
  input wire logic       o_erase_all,
  input wire logic       o_array_sel,
  input wire logic       o_once_sel,
  input wire logic       o_read_invalid,
  input wire logic       o_unsecure
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  // Starts, status while busy, gating and security
  a_prog_lone_pulse: assert property (o_prog |=> !o_prog [*8])
    else $error("program start is not a lone pulse");
  a_erase_lone_pulse: assert property (o_erase_all |=>
    !o_erase_all [*8])
    else $error("erase start is not a lone pulse");
  a_busy_status: assert property (o_prog ##1
    (i_rd && i_addr == 3'h3) |=> !o_rdata[7])
    else $error("complete flag set while busy");
  a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
  a_once_invalid: assert property (o_prog && o_once_sel |=>
    o_read_invalid [*8])
    else $error("flash reads valid during program once");
  a_once_noprot: assert property (o_once_sel && i_rd &&
    i_addr == 3'h3 |=> !o_rdata[4])
    else $error("protection flag seen during program once");
  a_prog_prot: assert property (o_prog && !o_once_sel |->
    !(o_array_sel ? i_ee_prot : i_flash_prot))
    else $error("program started in protected array");
  a_erase_prot: assert property (o_erase_all |->
    !i_flash_prot && !i_ee_prot)
    else $error("erase started with protection");
  a_mode_gate: assert property (o_prog || o_erase_all |-> i_mode_ok)
    else $error("start in forbidden mode");
  a_unsec_sticky: assert property (o_unsecure |=> o_unsecure)
    else $error("unsecure dropped");
  a_unsec_cause: assert property ($rose(o_unsecure) |->
    !$past(i_verify_err) && !i_flash_prot && !i_ee_prot)
    else $error("unsecure without clean erase");
endmodule : nvmpe_props
bind nvmpe_core nvmpe_props u_props (.*);
`default_nettype wire

// File: nvmpe_params.svh
/*
  Constants for the program/erase command sequencer: register offsets,
  field positions, command codes, parameter indices and limits.
  Assumes inclusion by its bare name from the design.
*/
`ifndef NVMPE_PARAMS_SVH
`define NVMPE_PARAMS_SVH

// Register offsets on the plain port
`define NVMPE_OFS_INDEX   3'h0
`define NVMPE_OFS_PARHI   3'h1
`define NVMPE_OFS_PARLO   3'h2
`define NVMPE_OFS_STATUS  3'h3
`define NVMPE_OFS_CONFIG  3'h4
// Status bits
`define NVMPE_ST_CCF      7
`define NVMPE_ST_ACC      5
`define NVMPE_ST_PROT     4
`define NVMPE_ST_VERR     1
`define NVMPE_ST_VUNC     0
`define NVMPE_STATUS_RST  8'h80
// Command codes
`define NVMPE_CMD_PGM     8'h06
`define NVMPE_CMD_ONCE    8'h07
`define NVMPE_CMD_ERALL   8'h08
// Parameter indices at launch
`define NVMPE_IX_HDR      3'h0
`define NVMPE_IX_ONE      3'h3
`define NVMPE_IX_TWO      3'h5
// Program-once phrase index limit
`define NVMPE_ONCE_MAX    16'h0007
// Flash and EEPROM block tops (longword-aligned last address, low 16 bits)
`define NVMPE_FLASH_LAST  16'h0FFC
`define NVMPE_EE_LAST     16'h00FC
// Busy time of an embedded operation in cycles
`define NVMPE_OP_CYCLES   8'h20

`endif

// File: nvmpe_pkg.sv
/*
  Types for the program/erase command sequencer.
  Assumes nvmpe_params.svh is on the include path.
*/
package nvmpe_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    NVMPE_IDLE, NVMPE_CHECK, NVMPE_BLANK, NVMPE_PROG, NVMPE_VERIFY
  } nvmpe_state_t;

  // Status flags bundle
  typedef struct packed {
    logic ccf;
    logic acc;
    logic prot;
    logic verr;
    logic vunc;
  } nvmpe_flags_t;
endpackage : nvmpe_pkg

// File: tb.sv
/* Bench for nvmpe_core: table of commands, status and start notes.
   Assumes the design and its checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        I_CLK, I_RESETN, i_wr, i_rd, rd_d;
  logic [2:0]  i_addr;
  logic [7:0]  i_wdata, o_rdata;
  logic        i_mode_ok, i_flash_prot, i_ee_prot, i_verify_err;
  logic        i_verify_unc, i_phrase_blank, i_phrase_ones;
  logic        o_prog, o_erase_all, o_array_sel, o_once_sel;
  logic        o_read_invalid, o_unsecure;
  logic [15:0] o_array_addr;
  logic [63:0] o_prog_data;
  logic [8:0]  sq[$];
  logic [84:0] pq[$];
  logic [8:0]  se;
  logic [84:0] pe;
  logic [3:0]  pk;
  integer      miscompares, checked, seed;

  nvmpe_core u_dut (.*);

  // Clock
  initial begin
    I_CLK = 1'b0;
    forever #5 I_CLK = ~I_CLK;
  end

  task automatic cmp(input string n, input logic [63:0] e,
                     input logic [63:0] s);
    checked++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask : cmp

  task automatic close_out;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge I_CLK);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge I_CLK);
    i_wr <= 1'b0;
  endtask : wr

  // Read with a note: bit 8 asks for a compare
  task automatic rd(input logic [2:0] a, input logic [8:0] e);
    @(posedge I_CLK);
    i_addr <= a;
    i_rd <= 1'b1;
    sq.push_back(e);
    @(posedge I_CLK);
    i_rd <= 1'b0;
    @(negedge I_CLK);
  endtask : rd

  task automatic poll;
    int n;
    n = 0;
    do begin
      rd(3'h3, 9'h000);
      n++;
    end while (o_rdata[7] !== 1'b1 && n < 200);
    if (o_rdata[7] !== 1'b1) cmp("complete", 64'd1, 64'd0);
  endtask : poll

  // Load parameters, launch, wait, check status
  task automatic run(input logic [7:0] c, input logic [23:0] ga,
                     input logic [2:0] ix, input logic [6:0] cnd,
                     input logic [7:0] ex);
    logic [63:0] d;
    @(posedge I_CLK);
    {i_mode_ok, i_flash_prot, i_ee_prot, i_verify_err, i_verify_unc,
     i_phrase_blank, i_phrase_ones} <= cnd;
    wr(3'h3, 8'h30);
    wr(3'h0, 8'h00);
    wr(3'h1, c);
    wr(3'h2, ga[23:16]);
    wr(3'h0, 8'h01);
    wr(3'h1, ga[15:8]);
    wr(3'h2, ga[7:0]);
    for (int i = 2; i < 6; i++) begin
      wr(3'h0, 8'(i));
      d = {d[47:0], 16'($random(seed))};
      wr(3'h1, d[15:8]);
      wr(3'h2, d[7:0]);
    end
    if (ix == 3'h3) d[31:0] = 32'hFFFFFFFF;
    // Every clean launch must show exactly one start pulse
    if (ex[5:4] == 2'b00)
      pq.push_back({c[3:0], ga[23], ga[15:0], d});
    wr(3'h0, {5'h00, ix});
    wr(3'h3, 8'h80);
    poll;
    rd(3'h3, {1'b1, ex});
  endtask : run

  // Compare results with the oldest notes
  always @(posedge I_CLK) rd_d <= i_rd;
  always @(negedge I_CLK) begin
    if (rd_d && sq.size() > 0) begin
      se = sq.pop_front();
      if (se[8]) cmp("status", 64'(se[7:0]), 64'(o_rdata));
    end
    if (o_prog || o_erase_all) begin
      if (pq.size() == 0) cmp("start", 64'd0, 64'd1);
      else begin
        pe = pq.pop_front();
        pk = pe[84:81];
        cmp("erase", 64'(pk == 4'h8), 64'(o_erase_all));
        cmp("once", 64'(pk == 4'h7), 64'(o_once_sel));
        cmp("invalid", 64'(pk == 4'h7), 64'(o_read_invalid));
        if (pk != 4'h8) cmp("data", pe[63:0], o_prog_data);
        if (pk == 4'h6) cmp("addr", 64'(pe[80:64]),
                            64'({o_array_sel, o_array_addr}));
      end
    end
  end

  // Watchdog
  initial begin
    #100000;
    miscompares++;
    close_out;
  end

  initial begin
    seed = 11881;
    miscompares = 0;
    checked = 0;
    I_RESETN = 1'b0;
    {i_addr, i_wdata, i_wr, i_rd} = '0;
    {i_mode_ok, i_flash_prot, i_ee_prot, i_verify_err, i_verify_unc,
     i_phrase_blank, i_phrase_ones} = '0;
    repeat (10) @(posedge I_CLK);
    I_RESETN <= 1'b1;
    rd(3'h3, 9'h180);
    run(8'h06, 24'h000100, 3'h5, 7'h40, 8'h80);
    run(8'h06, 24'h000FFC, 3'h3, 7'h40, 8'h80);
    run(8'h06, 24'h000FFC, 3'h5, 7'h40, 8'hA0);
    run(8'h06, 24'h000102, 3'h3, 7'h40, 8'hA0);
    run(8'h06, 24'h010000, 3'h3, 7'h40, 8'hA0);
    run(8'h06, 24'h000100, 3'h4, 7'h40, 8'hA0);
    run(8'h06, 24'h000100, 3'h1, 7'h40, 8'hA0);
    run(8'h06, 24'h000100, 3'h3, 7'h60, 8'h90);
    run(8'h06, 24'h8000FC, 3'h3, 7'h60, 8'h80);
    run(8'h06, 24'h800100, 3'h3, 7'h40, 8'hA0);
    run(8'h06, 24'h800000, 3'h3, 7'h50, 8'h90);
    run(8'h06, 24'h000100, 3'h3, 7'h48, 8'h82);
    run(8'h06, 24'h000100, 3'h3, 7'h4C, 8'h83);
    run(8'h07, 24'h000007, 3'h5, 7'h72, 8'h80);
    run(8'h07, 24'h000008, 3'h5, 7'h42, 8'hA0);
    run(8'h07, 24'h000000, 3'h3, 7'h42, 8'hA0);
    run(8'h07, 24'h000001, 3'h5, 7'h40, 8'hA0);
    run(8'h07, 24'h000001, 3'h5, 7'h41, 8'h80);
    run(8'h06, 24'h000100, 3'h3, 7'h02, 8'hA0);
    run(8'h07, 24'h000003, 3'h5, 7'h02, 8'hA0);
    run(8'h08, 24'h000000, 3'h0, 7'h02, 8'hA0);
    run(8'h08, 24'h000000, 3'h1, 7'h40, 8'hA0);
    run(8'h08, 24'h000000, 3'h0, 7'h50, 8'h90);
    run(8'h08, 24'h000000, 3'h0, 7'h48, 8'h82);
    cmp("unsecure", 64'd0, 64'(o_unsecure));
    run(8'h08, 24'h000000, 3'h0, 7'h40, 8'h80);
    cmp("unsecure", 64'd1, 64'(o_unsecure));
    cmp("left", 64'd0, 64'(pq.size()));
    // Reset after the last run drops the security release again
    I_RESETN <= 1'b0;
    repeat (2) @(posedge I_CLK);
    I_RESETN <= 1'b1;
    rd(3'h3, 9'h180);
    cmp("unsecure", 64'd0, 64'(o_unsecure));
    close_out;
  end
endmodule : tb
`default_nettype wire
